// file: hw/pgs_ms_timer.sv
// Millisecond tick divider and elapsed-millisecond counter
`default_nettype none

module pgs_ms_timer
#(
	parameter int CYCLES_PER_MS = pgs_pkg::CYC_PER_MS,
	parameter int MS_W          = pgs_pkg::MS_CNT_W
)
(
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire logic            restart,
	output logic                 tick,
	output logic [MS_W-1:0]      ms_count
);

	localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_MS - 1);

	logic [DIV_W-1:0] div_r;
	logic [MS_W-1:0]  ms_r;

	assign tick     = (div_r == DIV_LAST);
	assign ms_count = ms_r;

	always_ff @(posedge clk)
	begin
		if (srst || restart || tick)
			div_r <= '0;
		else
			div_r <= div_r + DIV_W'(1);
	end

	always_ff @(posedge clk)
	begin
		if (srst || restart)
			ms_r <= '0;
		else if (tick)
			ms_r <= ms_r + MS_W'(1);
	end

endmodule

`default_nettype wire

// file: hw/pgs_sequencer.sv
// Power-good sequencer with pin configuration and APB register file
`default_nettype none

module pgs_sequencer
#(
	parameter int CYCLES_PER_MS = pgs_pkg::CYC_PER_MS
)
(
	input  wire logic        CLOCK,
	input  wire logic        SRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             IRQ,
	// Hot swap side
	input  wire logic        POWER_UP_OK,
	input  wire logic        FAULT_IN,
	output logic             OUTPUT_SHUTDOWN,
	// Power-good pins, open drain
	input  wire logic        POWER_GOOD_OUT_FIRST_N_I,
	output logic             POWER_GOOD_OUT_FIRST_N_O,
	output logic             POWER_GOOD_OUT_FIRST_N_OE,
	input  wire logic        POWER_GOOD_OUT_SECOND_N_I,
	output logic             POWER_GOOD_OUT_SECOND_N_O,
	output logic             POWER_GOOD_OUT_SECOND_N_OE,
	input  wire logic        POWER_GOOD_VERIFY_IN_N,
	// Configuration pins
	input  wire logic        EE_WRITE_LOCK,
	input  wire logic [1:0]  ADDR_SELECT_UPPER,
	input  wire logic [1:0]  ADDR_SELECT_LOWER,
	output logic [6:0]       SERIAL_ADDR,
	output logic             SERIAL_BROADCAST,
	output logic             AUX_ANALOG_PIN_FOUR_ADC_SEL,
	// EEPROM write port
	input  wire logic        FAULT_LOG_REQ,
	input  wire logic [7:0]  FAULT_LOG_ADDR,
	input  wire logic [7:0]  FAULT_LOG_DATA,
	output logic             EE_WR_STB,
	output logic             EE_WR_FAULT_LOG,
	output logic [7:0]       EE_WR_ADDR,
	output logic [7:0]       EE_WR_DATA
);

	localparam int SYNC_W       = 10;
	localparam int PG_STEP_CYC  = pgs_pkg::PG_STEP_MS * CYCLES_PER_MS;
	localparam int VERIFY_CYC   = pgs_pkg::VERIFY_MS * CYCLES_PER_MS;
	localparam logic [pgs_pkg::MS_CNT_W-1:0] PG_LAST_MS = pgs_pkg::MS_CNT_W'(pgs_pkg::PG_STEP_MS - 1);
	localparam logic [pgs_pkg::MS_CNT_W-1:0] VF_LAST_MS = pgs_pkg::MS_CNT_W'(pgs_pkg::VERIFY_MS - 1);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync_meta_r;
	logic [SYNC_W-1:0] sync_r;

	assign pin_raw = {POWER_UP_OK, FAULT_IN, POWER_GOOD_VERIFY_IN_N, EE_WRITE_LOCK,
		ADDR_SELECT_UPPER, ADDR_SELECT_LOWER, POWER_GOOD_OUT_FIRST_N_I, POWER_GOOD_OUT_SECOND_N_I};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge CLOCK)
			begin
				if (SRST)
				begin
					sync_meta_r[gi] <= 1'b0;
					sync_r[gi]      <= 1'b0;
				end
				else
				begin
					sync_meta_r[gi] <= pin_raw[gi];
					sync_r[gi]      <= sync_meta_r[gi];
				end
			end
		end
	endgenerate

	logic       pu_ok_s;
	logic       fault_s;
	logic       verify_n_s;
	logic       lock_s;
	logic [1:0] adr_up_s;
	logic [1:0] adr_lo_s;
	logic       pg1_pin_s;
	logic       pg2_pin_s;

	assign {pu_ok_s, fault_s, verify_n_s, lock_s, adr_up_s, adr_lo_s, pg1_pin_s, pg2_pin_s} = sync_r;

	// ----------------------------------------------------------------
	// Address-select decode
	// ----------------------------------------------------------------
	// Returns {broadcast, address}; combinations not otherwise named map onto a small address block
	function automatic logic [7:0] addr_decode(input logic [1:0] up, input logic [1:0] lo);
		logic [7:0] res;
		res = {1'b0, pgs_pkg::ADDR_ALT_BASE + {3'h0, up, lo}};
		if (up == pgs_pkg::LVL_FLOAT && lo == pgs_pkg::LVL_FLOAT)
			res = {1'b0, pgs_pkg::ADDR_FLOAT_BOTH};
		else if (up == pgs_pkg::LVL_HIGH && lo == pgs_pkg::LVL_LOW)
			res = {1'b1, pgs_pkg::ADDR_FLOAT_BOTH};
		return res;
	endfunction

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			{SERIAL_BROADCAST, SERIAL_ADDR} <= {1'b0, pgs_pkg::ADDR_FLOAT_BOTH};
		else
			{SERIAL_BROADCAST, SERIAL_ADDR} <= addr_decode(adr_up_s, adr_lo_s);
	end

	// ----------------------------------------------------------------
	// Sequencing state machine
	// ----------------------------------------------------------------
	pgs_pkg::pgs_state_t state_r;
	pgs_pkg::pgs_state_t state_nxt;
	logic                pu_prev_r;
	logic                tick;
	logic [pgs_pkg::MS_CNT_W-1:0] ms_count;
	logic                restart;
	logic                step_done;
	logic                verify_done;
	logic                verify_ok;

	assign verify_ok   = !verify_n_s;
	assign step_done   = tick && (ms_count == PG_LAST_MS);
	assign verify_done = tick && (ms_count == VF_LAST_MS);
	assign restart     = (state_nxt != state_r);

	pgs_ms_timer
	#(
		.CYCLES_PER_MS (CYCLES_PER_MS),
		.MS_W          (pgs_pkg::MS_CNT_W)
	)
	u_timer
	(
		.clk      (CLOCK),
		.srst     (SRST),
		.restart  (restart),
		.tick     (tick),
		.ms_count (ms_count)
	);

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			pu_prev_r <= 1'b1;
		else
			pu_prev_r <= pu_ok_s;
	end

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pgs_pkg::ST_OFF:
				if (pu_ok_s && !pu_prev_r && !fault_s)
					state_nxt = pgs_pkg::ST_WAIT_FIRST;
			pgs_pkg::ST_WAIT_FIRST:
				if (fault_s || !pu_ok_s)
					state_nxt = pgs_pkg::ST_SHUTDOWN;
				else if (step_done)
					state_nxt = pgs_pkg::ST_WAIT_SECOND;
			pgs_pkg::ST_WAIT_SECOND:
				if (fault_s || !pu_ok_s)
					state_nxt = pgs_pkg::ST_SHUTDOWN;
				else if (step_done)
					state_nxt = pgs_pkg::ST_VERIFY;
			pgs_pkg::ST_VERIFY:
				// A verify seen in the last window cycle still counts
				if (fault_s || !pu_ok_s)
					state_nxt = pgs_pkg::ST_SHUTDOWN;
				else if (verify_ok)
					state_nxt = pgs_pkg::ST_ON;
				else if (verify_done)
					state_nxt = pgs_pkg::ST_SHUTDOWN;
			pgs_pkg::ST_ON:
				if (fault_s || !pu_ok_s || !verify_ok)
					state_nxt = pgs_pkg::ST_SHUTDOWN;
			pgs_pkg::ST_SHUTDOWN:
				// Held until the power-up indication drops, so a fresh one is needed
				if (!pu_ok_s)
					state_nxt = pgs_pkg::ST_OFF;
			default:
				state_nxt = pgs_pkg::ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			state_r <= pgs_pkg::ST_OFF;
		else
			state_r <= state_nxt;
	end

	logic pg1_on_r;
	logic pg2_on_r;

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			pg1_on_r        <= 1'b0;
			pg2_on_r        <= 1'b0;
			OUTPUT_SHUTDOWN <= 1'b0;
		end
		else
		begin
			pg1_on_r        <= state_nxt inside {pgs_pkg::ST_WAIT_SECOND, pgs_pkg::ST_VERIFY, pgs_pkg::ST_ON};
			pg2_on_r        <= state_nxt inside {pgs_pkg::ST_VERIFY, pgs_pkg::ST_ON};
			OUTPUT_SHUTDOWN <= (state_nxt == pgs_pkg::ST_SHUTDOWN);
		end
	end

	// Open drain: pull low while good, float otherwise
	assign POWER_GOOD_OUT_FIRST_N_O   = 1'b0;
	assign POWER_GOOD_OUT_FIRST_N_OE  = pg1_on_r;
	assign POWER_GOOD_OUT_SECOND_N_O  = 1'b0;
	assign POWER_GOOD_OUT_SECOND_N_OE = pg2_on_r;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic apb_wr;
	logic apb_setup;
	logic addr_hit;

	assign PREADY    = 1'b1;
	assign apb_wr    = PSEL && PENABLE && PWRITE;
	assign apb_setup = PSEL && !PENABLE;
	assign addr_hit  = PADDR inside {pgs_pkg::OFS_CTRL, pgs_pkg::OFS_STATUS, pgs_pkg::OFS_INT_STAT,
		pgs_pkg::OFS_INT_MASK, pgs_pkg::OFS_ADDR, pgs_pkg::OFS_EE_WRITE};
	assign PSLVERR   = PSEL && PENABLE && !addr_hit;

	logic [31:0]             ctrl_r;
	logic [pgs_pkg::INT_W-1:0] int_stat_r;
	logic [pgs_pkg::INT_W-1:0] int_mask_r;
	logic [pgs_pkg::INT_W-1:0] int_set;

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			ctrl_r <= pgs_pkg::CTRL_RST;
		else if (apb_wr && PADDR == pgs_pkg::OFS_CTRL)
			ctrl_r <= {31'h0, PWDATA[pgs_pkg::CTRL_AUX4_ADC]};
	end

	assign AUX_ANALOG_PIN_FOUR_ADC_SEL = ctrl_r[pgs_pkg::CTRL_AUX4_ADC];

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			int_mask_r <= pgs_pkg::INT_MASK_RST[pgs_pkg::INT_W-1:0];
		else if (apb_wr && PADDR == pgs_pkg::OFS_INT_MASK)
			int_mask_r <= PWDATA[pgs_pkg::INT_W-1:0];
	end

	// ----------------------------------------------------------------
	// EEPROM write path
	// ----------------------------------------------------------------
	logic        ee_host_req;
	logic        ee_refused;
	logic        ee_pend_r;
	logic [7:0]  ee_pend_addr_r;
	logic [7:0]  ee_pend_data_r;

	assign ee_host_req = apb_wr && PADDR == pgs_pkg::OFS_EE_WRITE;
	assign ee_refused  = ee_host_req && (lock_s || ee_pend_r);

	// A host write waits while fault logging holds the port
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			ee_pend_r      <= 1'b0;
			ee_pend_addr_r <= 8'h00;
			ee_pend_data_r <= 8'h00;
		end
		else if (ee_host_req && !ee_refused)
		begin
			ee_pend_r      <= 1'b1;
			ee_pend_addr_r <= PWDATA[pgs_pkg::EE_ADDR_LSB +: 8];
			ee_pend_data_r <= PWDATA[pgs_pkg::EE_DATA_LSB +: 8];
		end
		else if (!FAULT_LOG_REQ)
			ee_pend_r <= 1'b0;
	end

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
		begin
			EE_WR_STB       <= 1'b0;
			EE_WR_FAULT_LOG <= 1'b0;
			EE_WR_ADDR      <= 8'h00;
			EE_WR_DATA      <= 8'h00;
		end
		else if (FAULT_LOG_REQ)
		begin
			EE_WR_STB       <= 1'b1;
			EE_WR_FAULT_LOG <= 1'b1;
			EE_WR_ADDR      <= FAULT_LOG_ADDR;
			EE_WR_DATA      <= FAULT_LOG_DATA;
		end
		else if (ee_pend_r)
		begin
			EE_WR_STB       <= 1'b1;
			EE_WR_FAULT_LOG <= 1'b0;
			EE_WR_ADDR      <= ee_pend_addr_r;
			EE_WR_DATA      <= ee_pend_data_r;
		end
		else
		begin
			EE_WR_STB       <= 1'b0;
			EE_WR_FAULT_LOG <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	always_comb
	begin
		int_set = '0;
		int_set[pgs_pkg::INT_PG1]        = (state_r == pgs_pkg::ST_WAIT_FIRST) && (state_nxt == pgs_pkg::ST_WAIT_SECOND);
		int_set[pgs_pkg::INT_PG2]        = (state_r == pgs_pkg::ST_WAIT_SECOND) && (state_nxt == pgs_pkg::ST_VERIFY);
		int_set[pgs_pkg::INT_VERIFIED]   = (state_r == pgs_pkg::ST_VERIFY) && (state_nxt == pgs_pkg::ST_ON);
		int_set[pgs_pkg::INT_TIMEOUT]    = (state_r == pgs_pkg::ST_VERIFY) && verify_done && !verify_ok
			&& !fault_s && pu_ok_s;
		int_set[pgs_pkg::INT_SHUTDOWN]   = (state_r != pgs_pkg::ST_SHUTDOWN) && (state_nxt == pgs_pkg::ST_SHUTDOWN);
		int_set[pgs_pkg::INT_EE_REFUSED] = ee_refused;
	end

	// Set beats a same-cycle write-one-to-clear
	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			int_stat_r <= '0;
		else if (apb_wr && PADDR == pgs_pkg::OFS_INT_STAT)
			int_stat_r <= (int_stat_r & ~PWDATA[pgs_pkg::INT_W-1:0]) | int_set;
		else
			int_stat_r <= int_stat_r | int_set;
	end

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			IRQ <= 1'b0;
		else
			IRQ <= |(int_stat_r & int_mask_r);
	end

	// ----------------------------------------------------------------
	// Read data, captured in the setup phase
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (PADDR)
			pgs_pkg::OFS_CTRL:     rd_mux = ctrl_r;
			pgs_pkg::OFS_STATUS:   rd_mux = {21'h0, pg2_pin_s, pg1_pin_s, fault_s, pu_ok_s, lock_s,
				verify_ok, pg2_on_r, pg1_on_r, 3'(state_r)};
			pgs_pkg::OFS_INT_STAT: rd_mux = {26'h0, int_stat_r};
			pgs_pkg::OFS_INT_MASK: rd_mux = {26'h0, int_mask_r};
			pgs_pkg::OFS_ADDR:     rd_mux = {24'h0, SERIAL_BROADCAST, SERIAL_ADDR};
			pgs_pkg::OFS_EE_WRITE: rd_mux = {15'h0, ee_pend_r, ee_pend_addr_r, ee_pend_data_r};
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (SRST)
			PRDATA <= 32'h0000_0000;
		else if (apb_setup)
			PRDATA <= rd_mux;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [31:0] state_cyc_r;

	always_ff @(posedge CLOCK)
	begin
		if (SRST || restart)
			state_cyc_r <= 32'h0000_0000;
		else
			state_cyc_r <= state_cyc_r + 32'h0000_0001;
	end

	sequence seq_window_expired;
		state_r == pgs_pkg::ST_VERIFY && state_cyc_r == 32'(VERIFY_CYC - 1) && !verify_ok && !fault_s && pu_ok_s;
	endsequence

	sequence seq_shut_then_off;
		state_r == pgs_pkg::ST_SHUTDOWN && OUTPUT_SHUTDOWN && !pg1_on_r && !pg2_on_r ##1 !pg1_on_r && !pg2_on_r;
	endsequence

	AST_PG1_DELAY: assert property (@(posedge CLOCK) disable iff (SRST)
		$rose(pg1_on_r) |-> $past(state_cyc_r) == 32'(PG_STEP_CYC - 1) && $past(state_r) == pgs_pkg::ST_WAIT_FIRST)
		else $error("first power-good asserted at the wrong time");

	AST_PG2_DELAY: assert property (@(posedge CLOCK) disable iff (SRST)
		$rose(pg2_on_r) |-> $past(state_cyc_r) == 32'(PG_STEP_CYC - 1) && $past(state_r) == pgs_pkg::ST_WAIT_SECOND)
		else $error("second power-good asserted at the wrong time");

	AST_PG_ACTIVE_LOW: assert property (@(posedge CLOCK) disable iff (SRST)
		!POWER_GOOD_OUT_FIRST_N_O && !POWER_GOOD_OUT_SECOND_N_O && (POWER_GOOD_OUT_SECOND_N_OE -> POWER_GOOD_OUT_FIRST_N_OE))
		else $error("power-good outputs not driven low as required");

	AST_VERIFY_TIMEOUT: assert property (@(posedge CLOCK) disable iff (SRST)
		seq_window_expired |=> state_r == pgs_pkg::ST_SHUTDOWN && OUTPUT_SHUTDOWN && int_stat_r[pgs_pkg::INT_TIMEOUT])
		else $error("no shutdown after missing verify");

	AST_STAY_ON: assert property (@(posedge CLOCK) disable iff (SRST)
		state_r == pgs_pkg::ST_ON && verify_ok && !fault_s && pu_ok_s |=> state_r == pgs_pkg::ST_ON && pg2_on_r)
		else $error("left on state while verify held low");

	AST_LOCK_REFUSE: assert property (@(posedge CLOCK) disable iff (SRST)
		ee_host_req && lock_s |=> int_stat_r[pgs_pkg::INT_EE_REFUSED] ##1 !(EE_WR_STB && !EE_WR_FAULT_LOG))
		else $error("locked host write reached the EEPROM");

	AST_FAULT_LOG: assert property (@(posedge CLOCK) disable iff (SRST)
		FAULT_LOG_REQ |=> EE_WR_STB && EE_WR_FAULT_LOG && EE_WR_DATA == $past(FAULT_LOG_DATA))
		else $error("fault log entry not written");

	AST_ADDR_DECODE: assert property (@(posedge CLOCK) disable iff (SRST)
		adr_up_s == pgs_pkg::LVL_FLOAT && adr_lo_s == pgs_pkg::LVL_FLOAT |=> SERIAL_ADDR == 7'h2A && !SERIAL_BROADCAST)
		else $error("floating address pins decoded wrongly");

	AST_AUX_ADC: assert property (@(posedge CLOCK) disable iff (SRST)
		apb_wr && PADDR == pgs_pkg::OFS_CTRL |=> AUX_ANALOG_PIN_FOUR_ADC_SEL == $past(PWDATA[pgs_pkg::CTRL_AUX4_ADC]))
		else $error("aux pin mode not taken from control write");

	AST_SHUTDOWN_RELEASE: assert property (@(posedge CLOCK) disable iff (SRST)
		$rose(state_r == pgs_pkg::ST_SHUTDOWN) |-> seq_shut_then_off)
		else $error("power-good held during shutdown");

endmodule

`default_nettype wire

// file: include/pgs_pkg.sv
// Shared constants and types of the power-good sequencer
`default_nettype none

package pgs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PG_STEP_MS    = 256;
	localparam int VERIFY_MS     = 512;
	localparam int MS_CNT_W      = 10;
	localparam int SYNC_STAGES   = 2;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATUS   = 8'h04;
	localparam logic [7:0] OFS_INT_STAT = 8'h08;
	localparam logic [7:0] OFS_INT_MASK = 8'h0C;
	localparam logic [7:0] OFS_ADDR     = 8'h10;
	localparam logic [7:0] OFS_EE_WRITE = 8'h14;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_AUX4_ADC  = 0;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0001;
	localparam logic [31:0] INT_MASK_RST   = 32'h0000_0000;
	localparam int          INT_W          = 6;
	localparam int          INT_PG1        = 0;
	localparam int          INT_PG2        = 1;
	localparam int          INT_VERIFIED   = 2;
	localparam int          INT_TIMEOUT    = 3;
	localparam int          INT_SHUTDOWN   = 4;
	localparam int          INT_EE_REFUSED = 5;
	localparam int          EE_DATA_LSB    = 0;
	localparam int          EE_ADDR_LSB    = 8;
	localparam int          EE_PEND_BIT    = 16;

	// ----------------------------------------------------------------
	// Address-select pins: level codes from the pin detector
	// ----------------------------------------------------------------
	localparam logic [1:0] LVL_LOW        = 2'h0;
	localparam logic [1:0] LVL_HIGH       = 2'h1;
	localparam logic [1:0] LVL_FLOAT      = 2'h2;
	localparam logic [6:0] ADDR_FLOAT_BOTH = 7'h2A;
	localparam logic [6:0] ADDR_ALT_BASE   = 7'h20;

	typedef enum logic [2:0]
	{
		ST_OFF,
		ST_WAIT_FIRST,
		ST_WAIT_SECOND,
		ST_VERIFY,
		ST_ON,
		ST_SHUTDOWN
	} pgs_state_t;

endpackage

`default_nettype wire

// file: verification/pgs_partner.sv
// Model of the downstream converters and their supply monitor
`default_nettype none

module pgs_partner
(
	input  wire logic clk,
	input  wire logic answer_en,
	input  wire logic pg1_oe,
	input  wire logic pg2_oe,
	output logic      pg1_pin,
	output logic      pg2_pin,
	output logic      verify_n
);
	timeunit 1ns;
	timeprecision 1ps;

	int wait_cnt;

	// ----------------------------------------------------------------
	// Open-drain lines with pull-ups
	// ----------------------------------------------------------------
	assign pg1_pin = ~pg1_oe;
	assign pg2_pin = ~pg2_oe;

	initial
	begin
		verify_n = 1'b1;
		wait_cnt = 0;
	end

	// Confirms well inside the window, or never while answer_en is low
	always @(posedge clk)
	begin
		if (pg2_pin || !answer_en)
			wait_cnt <= 0;
		else if (wait_cnt < 100)
			wait_cnt <= wait_cnt + 1;
		verify_n <= !(wait_cnt == 100);
	end
endmodule

`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench of the power-good sequencer
`default_nettype none
`define CHK(nm, ex, got) \
	begin \
		n_compared++; \
		if ((got) !== (ex)) \
		begin \
			n_mismatch++; \
			$display("mismatch %s expected %0h seen %0h", nm, ex, got); \
		end \
	end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CPM  = 10;
	localparam int STEP = pgs_pkg::PG_STEP_MS * CPM;
	localparam int WIN  = pgs_pkg::VERIFY_MS * CPM;

	logic        CLOCK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, err, answer_en;
	logic [7:0]  PADDR, FAULT_LOG_ADDR, FAULT_LOG_DATA, EE_WR_ADDR, EE_WR_DATA, last_addr, last_data;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [1:0]  ADDR_SELECT_UPPER, ADDR_SELECT_LOWER;
	logic [6:0]  SERIAL_ADDR;
	logic        POWER_UP_OK, FAULT_IN, OUTPUT_SHUTDOWN, EE_WRITE_LOCK, FAULT_LOG_REQ, EE_WR_STB, EE_WR_FAULT_LOG;
	logic        SERIAL_BROADCAST, AUX_ANALOG_PIN_FOUR_ADC_SEL, last_log;
	logic        pg1_o, pg2_o, pg1_oe, pg2_oe, pg1_pin, pg2_pin, verify_n;
	int          n_mismatch, n_compared, cyc, n_host_wr, t0, t1;

	pgs_sequencer #(.CYCLES_PER_MS(CPM)) u_dut
	(
		.CLOCK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ,
		.POWER_UP_OK, .FAULT_IN, .OUTPUT_SHUTDOWN,
		.POWER_GOOD_OUT_FIRST_N_I(pg1_pin), .POWER_GOOD_OUT_FIRST_N_O(pg1_o), .POWER_GOOD_OUT_FIRST_N_OE(pg1_oe),
		.POWER_GOOD_OUT_SECOND_N_I(pg2_pin), .POWER_GOOD_OUT_SECOND_N_O(pg2_o), .POWER_GOOD_OUT_SECOND_N_OE(pg2_oe),
		.POWER_GOOD_VERIFY_IN_N(verify_n), .EE_WRITE_LOCK, .ADDR_SELECT_UPPER, .ADDR_SELECT_LOWER, .SERIAL_ADDR,
		.SERIAL_BROADCAST, .AUX_ANALOG_PIN_FOUR_ADC_SEL, .FAULT_LOG_REQ, .FAULT_LOG_ADDR, .FAULT_LOG_DATA,
		.EE_WR_STB, .EE_WR_FAULT_LOG, .EE_WR_ADDR, .EE_WR_DATA
	);

	pgs_partner u_far
	(
		.clk(CLOCK), .answer_en, .pg1_oe, .pg2_oe, .pg1_pin, .pg2_pin, .verify_n
	);

	// ----------------------------------------------------------------
	// Clock, strobe monitor and bus tasks
	// ----------------------------------------------------------------
	initial
	begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	// A refused host write shows up as a strobe that never came
	always @(posedge CLOCK)
	begin
		cyc <= cyc + 1;
		if (EE_WR_STB === 1'b1)
		begin
			n_host_wr <= n_host_wr + (EE_WR_FAULT_LOG ? 0 : 1);
			last_addr <= EE_WR_ADDR;
			last_data <= EE_WR_DATA;
			last_log  <= EE_WR_FAULT_LOG;
		end
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic stall();
		n_mismatch++;
		tally_and_finish();
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		PSEL    <= 1'b1;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLOCK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 20);
		if (n >= 20)
			stall();
		rd  = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return pg1_oe;
			1: return pg2_oe;
			default: return OUTPUT_SHUTDOWN;
		endcase
	endfunction

	task automatic wait_sig(input int s, input int lim);
		int n;
		n = 0;
		while (sig(s) !== 1'b1 && n < lim)
		begin
			@(posedge CLOCK);
			n++;
		end
		if (n >= lim)
			stall();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		cyc = 0;
		n_host_wr = 0;
		SRST = 1'b1;
		{PSEL, PENABLE, PWRITE, POWER_UP_OK, FAULT_IN, EE_WRITE_LOCK, FAULT_LOG_REQ} = 7'h00;
		PADDR = 8'h00;
		PWDATA = 32'h0000_0000;
		FAULT_LOG_ADDR = 8'h00;
		FAULT_LOG_DATA = 8'h00;
		ADDR_SELECT_UPPER = pgs_pkg::LVL_FLOAT;
		ADDR_SELECT_LOWER = pgs_pkg::LVL_FLOAT;
		answer_en = 1'b1;
		repeat (10) @(posedge CLOCK);
		SRST <= 1'b0;
		repeat (4) @(posedge CLOCK);
		apb(1'b0, pgs_pkg::OFS_CTRL, 32'h0);
		`CHK("ctrl", 32'h0000_0001, rd)
		apb(1'b1, pgs_pkg::OFS_CTRL, 32'h0);
		repeat (2) @(posedge CLOCK);
		`CHK("adc_sel", 1'b0, AUX_ANALOG_PIN_FOUR_ADC_SEL)
		apb(1'b0, pgs_pkg::OFS_ADDR, 32'h0);
		`CHK("addr_reg", 32'h0000_002A, rd)
		`CHK("serial_addr", 7'h2A, SERIAL_ADDR)
		ADDR_SELECT_UPPER <= pgs_pkg::LVL_HIGH;
		ADDR_SELECT_LOWER <= pgs_pkg::LVL_LOW;
		repeat (6) @(posedge CLOCK);
		`CHK("broadcast", 1'b1, SERIAL_BROADCAST)
		apb(1'b0, pgs_pkg::OFS_ADDR, 32'h0);
		`CHK("addr_bc", 1'b1, rd[7])
		apb(1'b0, 8'h3C, 32'h0);
		`CHK("unmapped", 1'b1, err)
		EE_WRITE_LOCK <= 1'b1;
		repeat (4) @(posedge CLOCK);
		apb(1'b1, pgs_pkg::OFS_EE_WRITE, 32'h0000_1234);
		repeat (6) @(posedge CLOCK);
		`CHK("host_refused", 0, n_host_wr)
		`CHK("irq_masked", 1'b0, IRQ)
		apb(1'b1, pgs_pkg::OFS_INT_MASK, 32'h0000_003F);
		repeat (2) @(posedge CLOCK);
		`CHK("irq", 1'b1, IRQ)
		apb(1'b0, pgs_pkg::OFS_INT_STAT, 32'h0);
		`CHK("refuse_flag", 1'b1, rd[pgs_pkg::INT_EE_REFUSED])
		apb(1'b1, pgs_pkg::OFS_INT_STAT, 32'h0000_003F);
		repeat (2) @(posedge CLOCK);
		`CHK("irq_clear", 1'b0, IRQ)
		FAULT_LOG_REQ <= 1'b1;
		FAULT_LOG_ADDR <= 8'h5A;
		FAULT_LOG_DATA <= 8'hC3;
		@(posedge CLOCK);
		FAULT_LOG_REQ <= 1'b0;
		repeat (2) @(posedge CLOCK);
		`CHK("log_addr", 8'h5A, last_addr)
		`CHK("log_data", 8'hC3, last_data)
		`CHK("log_src", 1'b1, last_log)
		EE_WRITE_LOCK <= 1'b0;
		repeat (4) @(posedge CLOCK);
		apb(1'b1, pgs_pkg::OFS_EE_WRITE, 32'h0000_6789);
		repeat (6) @(posedge CLOCK);
		`CHK("host_count", 1, n_host_wr)
		`CHK("host_addr", 8'h67, last_addr)
		`CHK("host_data", 8'h89, last_data)
		POWER_UP_OK <= 1'b1;
		t0 = cyc;
		wait_sig(0, STEP + 20);
		t1 = cyc;
		`CHK("pg1_delay", 1'b1, (t1 - t0) inside {[STEP : STEP + 6]})
		`CHK("pg1_drive", 1'b0, pg1_o)
		`CHK("pg2_early", 1'b0, pg2_oe)
		wait_sig(1, STEP + 20);
		`CHK("pg2_delay", STEP, cyc - t1)
		`CHK("pg2_drive", 1'b0, pg2_o)
		repeat (200) @(posedge CLOCK);
		`CHK("stay_on", 1'b0, OUTPUT_SHUTDOWN)
		apb(1'b0, pgs_pkg::OFS_STATUS, 32'h0);
		`CHK("state_on", 3'h4, rd[2:0])
		apb(1'b0, pgs_pkg::OFS_INT_STAT, 32'h0);
		`CHK("int_seq", 32'h0000_0007, rd)
		POWER_UP_OK <= 1'b0;
		repeat (10) @(posedge CLOCK);
		`CHK("pg_off", 2'h0, {pg1_oe, pg2_oe})
		answer_en <= 1'b0;
		POWER_UP_OK <= 1'b1;
		wait_sig(1, 3 * STEP);
		t1 = cyc;
		wait_sig(2, WIN + 20);
		`CHK("verify_window", 1'b1, (cyc - t1) inside {[WIN : WIN + 4]})
		repeat (2) @(posedge CLOCK);
		`CHK("pg_release", 2'h0, {pg1_oe, pg2_oe})
		apb(1'b0, pgs_pkg::OFS_INT_STAT, 32'h0);
		`CHK("int_timeout", 32'h0000_001F, rd)
		repeat (100) @(posedge CLOCK);
		`CHK("no_restart", 1'b0, pg1_oe)
		POWER_UP_OK <= 1'b0;
		repeat (10) @(posedge CLOCK);
		answer_en <= 1'b1;
		POWER_UP_OK <= 1'b1;
		wait_sig(0, STEP + 20);
		`CHK("restart", 1'b1, pg1_oe)
		FAULT_IN <= 1'b1;
		repeat (5) @(posedge CLOCK);
		`CHK("fault_shut", 1'b1, OUTPUT_SHUTDOWN)
		`CHK("fault_pg_off", 2'h0, {pg1_oe, pg2_oe})
		tally_and_finish();
	end
endmodule

`default_nettype wire
